// File: rtl/tdc_result_alu_readout.sv
/*
  Result arithmetic, result slot bank, load pointer, interrupt and serial readout
  of a two channel time to digital converter.
  Assumes raw hit data and measurement end come from the converter front end on clk_i,
  and that the serial host drives sck, cs_n and mosi asynchronously.
*/
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
// Notes on behaviour
// - Measurement end starts the arithmetic unit on the programmed hit selections.
// - Calibration off copies the 16-bit raw difference into the result slot.
// - Both selections equal to 5 switch the arithmetic unit off.
// - Latency about 1.24 us raw, 2.75 us calibrated, longer with predivider.
// - Stored result raises the interrupt when the ready source is enabled.
// - Each result bumps the load pointer, readable in status bits 0 to 2.
// - Read opcode with address shifts result MSB first, 16 or 32 clocks.
// - First rising serial clock of next transaction releases the interrupt.
// - Raw result is a 16-bit signed count of gate delays.
// - Calibrated result is 32-bit signed fixed point in reference periods.
// - Interval beyond the limit writes all ones.
// - One hit per request; host rewrites selections and waits.
// - Successive results fill consecutive slots; four results leave pointer at 4.
// - Calibration raw values are readable after the next measurement until init.
// - Mode two fine parts span start and stop to next reference edge.
// - Mode two coarse counter is 14 bits wide.
// - Mode two combined result spans 26 bits.
// - Mode two calibration measures one and two reference periods automatically.
// - Mode two result is valid within 4.6 us of arithmetic start.
// - Too short intervals are dropped when calibration is on; with calibration off the raw difference is still stored.
// - Configuration 0 bit 11 selects measurement mode two.
// - Result is first selection minus second; codes per hit map.
// - Configuration 2 bit 29 enables the ready interrupt source.
`timescale 1ns/10ps
`default_nettype none
module tdc_result_alu_readout
  import tdc_readout_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic meas_end_i,
  input wire logic [15:0] hit_time_i [0:15],
  input wire logic [COARSE_W-1:0] coarse_cnt_i,
  input wire logic too_short_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic accept_hits_o,
  output logic cal_request_o,
  output logic irq_out_n
);
  typedef enum logic [1:0] {
    ALU_IDLE = 2'b00,
    ALU_BUSY = 2'b01,
    ALU_DONE = 2'b10
  } alu_state_type;

  typedef enum logic [1:0] {
    SPI_CMD = 2'b00,
    SPI_DATA = 2'b01,
    SPI_SKIP = 2'b10
  } spi_state_type;

  logic [31:0] cfg0_q, cfg1_q, cfg2_q;
  logic [31:0] slot_q [0:SLOTS-1];
  logic [2:0] ptr_q;
  logic [15:0] cal1_q, cal2_q;
  logic cal_vis_q;
  alu_state_type alu_q;
  logic [15:0] lat_q;
  logic [31:0] res_q;
  logic irq_q;
  logic accept_q;
  logic cmd_end, cmd_init;
  logic wb_hit;
  hit_sel_type sel;
  logic mode2, calib;
  logic [1:0] div;
  spi_in_type s1_q, s2_q, s3_q;
  spi_state_type spi_q;
  logic [7:0] sh_in_q;
  logic [2:0] bit_cnt_q;
  logic [5:0] out_cnt_q;
  logic [31:0] sh_out_q;
  logic miso_q;
  logic first_q;
  logic sck_rise, sck_fall, spi_init;

  // Picks a raw hit time from a selection code; calibration codes yield stored values.
  function automatic logic [15:0] pick(input logic [3:0] code, input logic [15:0] c1,
                                       input logic [15:0] c2, input logic [15:0] h [0:15]);
    logic [15:0] v;
    v = h[code];
    if (code == SEL_CAL1) begin
      v = c1;
    end else if (code == SEL_CAL2) begin
      v = c2;
    end
    return v;
  endfunction

  assign mode2 = cfg0_q[MODE2_BIT];
  assign calib = cfg0_q[CALIB_BIT] | mode2;
  assign div = cfg0_q[DIV_LSB +: 2];
  assign sel.minu = mode2 ? cfg1_q[MINU2_LSB +: 4] : cfg1_q[MINU_LSB +: 4];
  assign sel.subt = mode2 ? cfg1_q[SUBT2_LSB +: 4] : cfg1_q[SUBT_LSB +: 4];
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign cmd_end = (wb_hit & wb_we_i & (wb_adr_i == CMD_OFF) & wb_sel_i[0] & wb_dat_i[CMD_END_BIT]) | meas_end_i;
  assign cmd_init = (wb_hit & wb_we_i & (wb_adr_i == CMD_OFF) & wb_sel_i[0] & wb_dat_i[CMD_INIT_BIT]) | spi_init;

  // Wishbone slave: one wait state, ack for one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg0_q <= CFG0_RST;
      cfg1_q <= CFG1_RST;
      cfg2_q <= CFG2_RST;
    end else if (wb_hit & wb_we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          if (wb_adr_i == CFG0_OFF) begin
            cfg0_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
          if (wb_adr_i == CFG1_OFF) begin
            cfg1_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
          if (wb_adr_i == CFG2_OFF) begin
            cfg2_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit & ~wb_we_i) begin
      unique case (wb_adr_i)
        CFG0_OFF: wb_dat_o <= cfg0_q;
        CFG1_OFF: wb_dat_o <= cfg1_q;
        CFG2_OFF: wb_dat_o <= cfg2_q;
        STAT_OFF: wb_dat_o <= {28'h0000000, alu_q == ALU_BUSY, ptr_q};
        MEAS_OFF: wb_dat_o <= {30'h0, accept_q, ~irq_q};
        HITA_OFF: wb_dat_o <= slot_q[ptr_q - 3'h1];
        HITB_OFF: wb_dat_o <= res_q;
        CAL_OFF: wb_dat_o <= cal_vis_q ? {cal2_q, cal1_q} : 32'h0000_0000;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Hit acceptance: init arms, measurement end closes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accept_q <= 1'b0;
    end else if (cmd_init) begin
      accept_q <= 1'b1;
    end else if (cmd_end) begin
      accept_q <= 1'b0;
    end
  end
  assign accept_hits_o = accept_q;
  assign cal_request_o = meas_end_i & calib;

  // Calibration values, visible after the following measurement until init.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal1_q <= 16'h0000;
      cal2_q <= 16'h0000;
      cal_vis_q <= 1'b0;
    end else if (meas_end_i & calib) begin
      cal1_q <= hit_time_i[SEL_CAL1];
      cal2_q <= hit_time_i[SEL_CAL2];
      cal_vis_q <= 1'b1;
    end else if (cmd_init) begin
      cal_vis_q <= 1'b0;
    end
  end

  // Arithmetic unit: start, latency count, result.
  always_ff @(posedge clk_i) begin
    logic [15:0] a, b, grad;
    logic signed [31:0] diff;
    logic [31:0] q;
    a = pick(sel.minu, cal1_q, cal2_q, hit_time_i);
    b = pick(sel.subt, cal1_q, cal2_q, hit_time_i);
    grad = cal2_q - cal1_q;
    diff = 32'(signed'(a)) - 32'(signed'(b));
    q = 32'h0000_0000;
    if (rst_i) begin
      alu_q <= ALU_IDLE;
      lat_q <= 16'h0000;
      res_q <= 32'h0000_0000;
    end else begin
      unique case (alu_q)
        ALU_IDLE: begin
          if (cmd_end & ~(sel.minu == SEL_OFF && sel.subt == SEL_OFF)) begin
            alu_q <= ALU_BUSY;
            if (mode2) begin
              lat_q <= 16'(LAT_MODE2_CYC);
            end else if (calib && div == 2'h0) begin
              lat_q <= 16'(LAT_CAL_CYC);
            end else if (calib && div == 2'h1) begin
              lat_q <= 16'(LAT_CAL_DIV1_CYC);
            end else if (calib) begin
              lat_q <= 16'(LAT_CAL_DIV2_CYC);
            end else begin
              lat_q <= 16'(LAT_RAW_CYC);
            end
          end
        end
        ALU_BUSY: begin
          if (lat_q > 16'h0001) begin
            lat_q <= lat_q - 16'h0001;
          end else begin
            alu_q <= ALU_DONE;
            if (!calib) begin
              res_q <= {16'h0000, diff[15:0]};
            end else if (too_short_i) begin
              res_q <= res_q;
            end else if (sel.minu == SEL_CAL1 || sel.minu == SEL_CAL2) begin
              res_q <= {16'h0000, a};
            end else if (grad == 16'h0000 ||
                         (diff[31] ? (-diff >= (32'(grad) <<< 1)) : (diff >= (32'(grad) <<< 1)))) begin
              res_q <= OVERFLOW_VAL;
            end else begin
              q = 32'((diff <<< 16) / signed'({16'h0000, grad}));
              if (mode2) begin
                q = q + {2'b00, coarse_cnt_i, 16'h0000};
                q = {{(32-RANGE_W){q[RANGE_W-1]}}, q[RANGE_W-1:0]};
              end
              res_q <= q;
            end
          end
        end
        ALU_DONE: alu_q <= ALU_IDLE;
        default: alu_q <= ALU_IDLE;
      endcase
    end
  end

  // Result slots and load pointer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= 3'h0;
      for (int i = 0; i < SLOTS; i++) begin
        slot_q[i] <= 32'h0000_0000;
      end
    end else if (alu_q == ALU_DONE && !(calib && too_short_i)) begin
      slot_q[ptr_q] <= res_q;
      ptr_q <= ptr_q + 3'h1;
    end else if (cmd_init) begin
      ptr_q <= 3'h0;
    end
  end

  // Interrupt: set wins over clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else if (alu_q == ALU_DONE && cfg2_q[ALU_IRQ_BIT] && !(calib && too_short_i)) begin
      irq_q <= 1'b1;
    end else if (sck_rise & first_q) begin
      irq_q <= 1'b0;
    end
  end
  assign irq_out_n = ~irq_q;

  // Serial pin synchronisers; only the second stage and later are read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      s2_q <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      s3_q <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
    end else begin
      s1_q <= '{sck: sck_i, cs_n: cs_n_i, mosi: mosi_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign sck_rise = s2_q.sck & ~s3_q.sck & ~s2_q.cs_n;
  assign sck_fall = ~s2_q.sck & s3_q.sck & ~s2_q.cs_n;
  assign spi_init = sck_rise & (spi_q == SPI_CMD) & (bit_cnt_q == 3'h7) & ({sh_in_q[6:0], s2_q.mosi} == OP_INIT);

  // Serial readout: opcode in, result out MSB first.
  always_ff @(posedge clk_i) begin
    if (rst_i || s2_q.cs_n) begin
      spi_q <= SPI_CMD;
      sh_in_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      out_cnt_q <= 6'h00;
      sh_out_q <= 32'h0000_0000;
      miso_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      if (sck_rise) begin
        first_q <= 1'b0;
      end
      unique case (spi_q)
        SPI_CMD: begin
          if (sck_rise) begin
            sh_in_q <= {sh_in_q[6:0], s2_q.mosi};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              if (sh_in_q[6:2] == OP_READ) begin
                spi_q <= SPI_DATA;
                out_cnt_q <= calib ? 6'h20 : 6'h10;
                sh_out_q <= calib ? slot_q[{sh_in_q[1:0], s2_q.mosi}]
                                  : {slot_q[{sh_in_q[1:0], s2_q.mosi}][15:0], 16'h0000};
              end else begin
                spi_q <= SPI_SKIP;
              end
            end
          end
        end
        SPI_DATA: begin
          if (sck_fall && out_cnt_q != 6'h00) begin
            miso_q <= sh_out_q[31];
            sh_out_q <= {sh_out_q[30:0], 1'b0};
            out_cnt_q <= out_cnt_q - 6'h01;
          end
        end
        SPI_SKIP: spi_q <= SPI_SKIP;
        default: spi_q <= SPI_CMD;
      endcase
    end
  end
  assign miso_o = miso_q;
  assign miso_oe_o = (spi_q == SPI_DATA) & ~s2_q.cs_n;
endmodule
`default_nettype wire

// File: pkg/tdc_readout_pkg.sv
/*
  Package for the converter result arithmetic and readout block: register map,
  field positions, opcodes, timing counts and the carrier structs.
  Assumes a 25 MHz system clock and a classic Wishbone register bus.
*/
`default_nettype none
package tdc_readout_pkg;
  localparam int CLK_MHZ = 25;
  // Register byte offsets.
  localparam logic [7:0] CFG0_OFF = 8'h00;
  localparam logic [7:0] CFG1_OFF = 8'h04;
  localparam logic [7:0] CFG2_OFF = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h0c;
  localparam logic [7:0] MEAS_OFF = 8'h10;
  localparam logic [7:0] HITA_OFF = 8'h14;
  localparam logic [7:0] HITB_OFF = 8'h18;
  localparam logic [7:0] CAL_OFF = 8'h1c;
  localparam logic [7:0] CMD_OFF = 8'h20;
  // Field positions.
  localparam int MODE2_BIT = 11;
  localparam int CALIB_BIT = 13;
  localparam int DIV_LSB = 20;
  localparam int MINU_LSB = 16;
  localparam int SUBT_LSB = 20;
  localparam int MINU2_LSB = 24;
  localparam int SUBT2_LSB = 28;
  localparam int ALU_IRQ_BIT = 29;
  localparam int STAT_BUSY_BIT = 3;
  localparam int CMD_END_BIT = 0;
  localparam int CMD_INIT_BIT = 1;
  // Reset values.
  localparam logic [31:0] CFG0_RST = 32'h0000_0000;
  localparam logic [31:0] CFG1_RST = 32'h0000_0000;
  localparam logic [31:0] CFG2_RST = 32'h0000_0000;
  // Hit selection codes.
  localparam logic [3:0] SEL_START = 4'h0;
  localparam logic [3:0] SEL_OFF = 4'h5;
  localparam logic [3:0] SEL_CAL1 = 4'h6;
  localparam logic [3:0] SEL_CAL2 = 4'h7;
  localparam logic [3:0] SEL_CH2_BASE = 4'h9;
  // Result values and widths.
  localparam logic [31:0] OVERFLOW_VAL = 32'hffff_ffff;
  localparam int COARSE_W = 14;
  localparam int RANGE_W = 26;
  localparam int SLOTS = 8;
  // Serial read opcode: upper five bits, address in the lower three.
  localparam logic [4:0] OP_READ = 5'b10110;
  localparam logic [7:0] OP_INIT = 8'h70;
  // Arithmetic latency figures in nanoseconds at 3.0 V.
  localparam int LAT_RAW_NS = 1240;
  localparam int LAT_CAL_NS = 2750;
  localparam int LAT_CAL_DIV1_NS = 4250;
  localparam int LAT_CAL_DIV2_NS = 7260;
  localparam int LAT_MODE2_NS = 4600;
  localparam int LAT_RAW_CYC = (LAT_RAW_NS * CLK_MHZ + 999) / 1000;
  localparam int LAT_CAL_CYC = (LAT_CAL_NS * CLK_MHZ + 999) / 1000;
  localparam int LAT_CAL_DIV1_CYC = (LAT_CAL_DIV1_NS * CLK_MHZ + 999) / 1000;
  localparam int LAT_CAL_DIV2_CYC = (LAT_CAL_DIV2_NS * CLK_MHZ + 999) / 1000;
  localparam int LAT_MODE2_CYC = (LAT_MODE2_NS * CLK_MHZ) / 1000;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } spi_in_type;

  typedef struct packed {
    logic [3:0] minu;
    logic [3:0] subt;
  } hit_sel_type;
endpackage
`default_nettype wire

// File: verification/tdc_result_alu_readout_props.sv
/*
  Port checker for the result readout block.
  Assumes it is bound into the block and sees only the block's ports.
*/
`timescale 1ns/10ps
`default_nettype none
module alu_readout_props
  import tdc_readout_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic meas_end_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic miso_oe_o,
  input wire logic accept_hits_o,
  input wire logic cal_request_o,
  input wire logic irq_out_n
);
  logic [7:0] since_end_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles since the last measurement end, saturating.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_end_q <= 8'hff;
    end else if (meas_end_i) begin
      since_end_q <= 8'h00;
    end else if (since_end_q != 8'hff) begin
      since_end_q <= since_end_q + 8'h01;
    end
  end
  sequence ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> ack_pulse)
    else $error("ack not a single pulse one cycle after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > CMD_OFF |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  irq_latency_a: assert property ($fell(irq_out_n) |-> since_end_q inside {[8'h14:8'hc8]})
    else $error("interrupt not tied to a result");
  irq_release_a: assert property ($rose(sck_i) && !cs_n_i |-> ##[1:5] irq_out_n)
    else $error("interrupt not released by serial clock");
  cal_req_a: assert property (cal_request_o |-> meas_end_i)
    else $error("calibration request without measurement end");
  accept_close_a: assert property (meas_end_i |=> !accept_hits_o)
    else $error("hits still accepted after measurement end");
  miso_release_a: assert property ($rose(cs_n_i) |-> ##[1:5] !miso_oe_o)
    else $error("serial data still driven after deselect");
  reset_idle_a: assert property (disable iff (1'h0) rst_i |=> !wb_ack_o && irq_out_n && !miso_oe_o)
    else $error("outputs not idle in reset");
endmodule
bind tdc_result_alu_readout alu_readout_props chk (.clk_i, .rst_i, .wb_adr_i, .wb_dat_o, .wb_we_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .meas_end_i, .sck_i, .cs_n_i, .miso_oe_o, .accept_hits_o,
  .cal_request_o, .irq_out_n);
`default_nettype wire

// File: verification/spi_host_model.sv
/*
  Serial host model: clocks an opcode MSB first and shifts back a result.
  Assumes a 320 ns serial clock that stands low outside frames.
*/
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  initial begin
    sck_o = 1'h0;
    cs_n_o = 1'h1;
    mosi_o = 1'h0;
  end
  task automatic xfer(input logic [7:0] op, input int nbits, output logic [31:0] rx);
    rx = 32'h0;
    #213 cs_n_o = 1'h0;
    for (int i = 0; i < 8 + nbits; i++) begin
      mosi_o = (i < 8) ? op[7 - i] : ~mosi_o;
      #160 sck_o = 1'h1;
      if (i >= 8) begin
        rx = {rx[30:0], miso_oe_i ? miso_i : 1'hx};
      end
      #160 sck_o = 1'h0;
    end
    #200 cs_n_o = 1'h1;
    mosi_o = ~mosi_o;
    #400;
  endtask
endmodule
`default_nettype wire

// File: verification/tdc_result_alu_readout_bench.sv
/*
  Self-checking bench for the result readout block.
  Assumes the serial host model drives the serial pins.
*/
`timescale 1ns/10ps
`default_nettype none
module tdc_result_alu_readout_bench
  import tdc_readout_pkg::*;
;
  typedef struct packed {
    logic [31:0] cfg0;
    logic [31:0] cfg1;
    logic [13:0] coarse;
    logic [31:0] res;
    logic [5:0] nbits;
  } row_type;
  localparam row_type ROWS [0:5] = '{
    '{32'h0, 32'h0001_0000, 14'h0, 32'h0000_0040, 6'h10},
    '{32'h0, 32'h0092_0000, 14'h0, 32'h0000_fe40, 6'h10},
    '{32'h0000_2000, 32'h0001_0000, 14'h0, 32'h0001_0000, 6'h20},
    '{32'h0020_2000, 32'h0010_0000, 14'h0, 32'hffff_0000, 6'h20},
    '{32'h0000_2000, 32'h0004_0000, 14'h0, 32'hffff_ffff, 6'h20},
    '{32'h0000_2800, 32'h0100_0000, 14'h3, 32'h0004_0000, 6'h20}};
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, meas_end_i, too_short_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, rx, m;
  logic [3:0] wb_sel_i;
  logic [15:0] hit_time_i [0:15];
  logic [COARSE_W-1:0] coarse_cnt_i;
  logic sck_i, cs_n_i, mosi_i, miso_o, miso_oe_o, accept_hits_o, cal_request_o, irq_out_n;
  int err_total, n_compared, i, n;
  tdc_result_alu_readout dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .meas_end_i, .hit_time_i, .coarse_cnt_i, .too_short_i, .sck_i,
    .cs_n_i, .mosi_i, .miso_o, .miso_oe_o, .accept_hits_o, .cal_request_o, .irq_out_n);
  spi_host_model host (.sck_o(sck_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i), .miso_i(miso_o),
    .miso_oe_i(miso_oe_o));
  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end
  task report_and_stop;
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", name, e, g);
      err_total++;
    end
  endtask
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    k = 0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1 && k < 16) begin
      @(posedge clk_i);
      k++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (k >= 16) begin
      $display("mismatch wb ack expected 1 seen %h", wb_ack_o);
      err_total++;
    end
  endtask
  task end_meas(input int idle);
    @(posedge clk_i);
    meas_end_i <= 1'h1;
    @(posedge clk_i);
    meas_end_i <= 1'h0;
    repeat (idle) @(posedge clk_i);
  endtask
  initial begin
    #2000000;
    err_total++;
    report_and_stop();
  end
  initial begin
    rst_i = 1'h1;
    {wb_we_i, wb_cyc_i, wb_stb_i, meas_end_i, too_short_i} = 5'h0;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    coarse_cnt_i = 14'h0;
    err_total = 0;
    n_compared = 0;
    for (i = 0; i < 16; i++) hit_time_i[i] = 16'(i * 64);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(CFG0_OFF, 1'h0, 32'h0);
    chk("cfg0 reset", CFG0_RST, q);
    wb(CFG2_OFF, 1'h0, 32'h0);
    chk("cfg2 reset", CFG2_RST, q);
    wb(CFG2_OFF, 1'h1, 32'h2000_0000);
    host.xfer(OP_INIT, 0, rx);
    chk("accept", 32'h1, {31'h0, accept_hits_o});
    for (i = 0; i < 6; i++) begin
      wb(CFG0_OFF, 1'h1, ROWS[i].cfg0);
      wb(CFG1_OFF, 1'h1, ROWS[i].cfg1);
      coarse_cnt_i <= ROWS[i].coarse;
      end_meas(0);
      n = 0;
      while (irq_out_n !== 1'h0 && n < 400) begin
        @(posedge clk_i);
        n++;
      end
      chk("irq set", 32'h0, {31'h0, irq_out_n});
      m = (ROWS[i].nbits == 6'h10) ? 32'h0000_ffff : 32'hffff_ffff;
      wb(HITB_OFF, 1'h0, 32'h0);
      chk("last result", ROWS[i].res & m, q & m);
      wb(HITA_OFF, 1'h0, 32'h0);
      chk("last slot", ROWS[i].res & m, q & m);
      wb(STAT_OFF, 1'h0, 32'h0);
      chk("pointer", 32'(i + 1), q & 32'h7);
      host.xfer({OP_READ, 3'(i)}, int'(ROWS[i].nbits), rx);
      chk("serial result", ROWS[i].res & m, rx & m);
      chk("irq released", 32'h1, {31'h0, irq_out_n});
    end
    wb(CFG0_OFF, 1'h1, 32'h0000_2000);
    wb(CFG1_OFF, 1'h1, 32'h0055_0000);
    end_meas(200);
    wb(STAT_OFF, 1'h0, 32'h0);
    chk("pointer alu off", 32'h6, q & 32'h7);
    wb(CFG1_OFF, 1'h1, 32'h0001_0000);
    too_short_i <= 1'h1;
    end_meas(200);
    too_short_i <= 1'h0;
    wb(STAT_OFF, 1'h0, 32'h0);
    chk("pointer short", 32'h6, q & 32'h7);
    chk("irq short", 32'h1, {31'h0, irq_out_n});
    wb(CFG2_OFF, 1'h1, 32'h0);
    end_meas(200);
    wb(STAT_OFF, 1'h0, 32'h0);
    chk("pointer masked", 32'h7, q & 32'h7);
    chk("irq masked", 32'h1, {31'h0, irq_out_n});
    wb(CAL_OFF, 1'h0, 32'h0);
    chk("cal raw", 32'h01c0_0180, q);
    host.xfer(OP_INIT, 0, rx);
    wb(CAL_OFF, 1'h0, 32'h0);
    chk("cal hidden", 32'h0, q);
    wb(STAT_OFF, 1'h0, 32'h0);
    chk("pointer init", 32'h0, q & 32'h7);
    wb(8'h40, 1'h0, 32'h0);
    chk("unmapped", 32'h0, q);
    end_meas(2);
    chk("accept closed", 32'h0, {31'h0, accept_hits_o});
    repeat (100) @(posedge clk_i);
    wb(CMD_OFF, 1'h1, 32'h0000_0002);
    chk("bus init accept", 32'h1, {31'h0, accept_hits_o});
    wb(STAT_OFF, 1'h0, 32'h0);
    chk("pointer bus init", 32'h0, q & 32'h7);
    wb(CMD_OFF, 1'h1, 32'h0000_0001);
    repeat (100) @(posedge clk_i);
    wb(STAT_OFF, 1'h0, 32'h0);
    chk("pointer bus end", 32'h1, q & 32'h7);
    chk("bus end accept", 32'h0, {31'h0, accept_hits_o});
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    chk("reset irq", 32'h1, {31'h0, irq_out_n});
    chk("reset accept", 32'h0, {31'h0, accept_hits_o});
    rst_i <= 1'h0;
    wb(CFG0_OFF, 1'h0, 32'h0);
    chk("cfg0 after reset", CFG0_RST, q);
    wb(STAT_OFF, 1'h0, 32'h0);
    chk("pointer after reset", 32'h0, q & 32'h7);
    report_and_stop();
  end
endmodule
`default_nettype wire
